//--- rtl/ulm_pkg.sv
`default_nettype none
package ulm_pkg;

  // register offsets on the 4-bit I/O address
  localparam logic [3:0] ADR_DATA  = 4'h8;
  localparam logic [3:0] ADR_IEN   = 4'h9;
  localparam logic [3:0] ADR_FCTL  = 4'hA;
  localparam logic [3:0] ADR_LCTL  = 4'hB;
  localparam logic [3:0] ADR_MCTL  = 4'hC;
  localparam logic [3:0] ADR_LSTAT = 4'hD;
  localparam logic [3:0] ADR_MSTAT = 4'hE;
  localparam logic [3:0] ADR_SCR   = 4'hF;

  // line_format_control fields
  localparam int LC_DIV   = 7;
  localparam int LC_BRK   = 6;
  localparam int LC_STICK = 5;
  localparam int LC_EVEN  = 4;
  localparam int LC_PAR   = 3;
  localparam int LC_STOP  = 2;
  // modem_line_control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_RI   = 2;
  localparam int MC_IRQ  = 3;
  localparam int MC_LOOP = 4;
  // queue_control fields
  localparam int FC_EN  = 0;
  localparam int FC_RXR = 1;
  localparam int FC_TXR = 2;
  localparam int FC_DMA = 3;

  // reset values
  localparam logic [7:0]  LCTL_RST = 8'h00;
  localparam logic [4:0]  MCTL_RST = 5'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;

  // 16x oversampling counts (last tick index)
  localparam logic [4:0] TK_HALF = 5'h07;
  localparam logic [4:0] TK_BIT  = 5'h0F;
  localparam logic [4:0] TK_S15  = 5'h17;
  localparam logic [4:0] TK_S2   = 5'h1F;

  // receive trigger levels
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } ulm_state_t;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } ulm_rx_char_t;

  function automatic logic ulm_parity(input logic [7:0] d, input logic [1:0] wl,
                                      input logic even, input logic stick);
    logic [7:0] m;
    m = d & (8'hFF >> (2'd3 - wl));
    ulm_parity = stick ? ~even : (even ? ^m : ~^m);
  endfunction

endpackage
`default_nettype wire

//--- rtl/ulm_uart.sv
// Notes on behaviour
// R1: dlab=1 maps offsets 8/9 to divisor bytes, else data and interrupt enable.
// R2: divisor is 16 bits, low byte bits 0-7, high byte bits 8-15.
// R3: characters go out and come in least significant bit first.
// R4: break control holds serial output low outside loopback; transmitter keeps running.
// R5: even select picks parity sense; stick parity forces bit to inverse of even.
// R6: parity bit sits between last data bit and first stop bit.
// R7: long stop gives 1.5 stop bits for 5-bit words, 2 otherwise.
// R8: word length bits select five to eight data bits.
// R9: queue error flag set by any queued bad char, cleared on read when none.
// R10: transmitter idle when holding storage and shifter both empty.
// R11: holding empty set when holding storage drains, cleared by data write.
// R12: break, framing and parity flags, head-of-queue, cleared by status read.
// R13: overrun flag on overwritten character, cleared by status read.
// R14: receive ready while any received character waits.
// R15: loopback drives output high, isolates input, loops shifter, modem outs off.
// R16: loopback feeds modem inputs from handshake control bits.
// R17: control bit 3 gates interrupt; bits 1 and 0 drive inverted RTS, DTR.
// R18: status bits 7-4 are inverted modem pins, or control bits in loopback.
// R19: delta bits latch changes since last read; ring latches trailing edge.
// R20: trigger bits select 1, 4, 8 or 14; request once fill exceeds it.
// R21: queue reset bits clear counters and self-clear.
// R22: bit 0 enables queue mode; DMA mode 1 only with queues enabled.
// R23: sixteen-entry queues; transmit entries are bytes, receive entries are a byte plus break, framing and parity bits.
// R24: baud generator gives 16x bit rate for transmitter and receiver.
// R25: receiver validates start at mid-bit and samples mid-bit.
`timescale 1ns/1ps
`default_nettype none

module ulm_fifo
  import ulm_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("ulm_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_ff != (AW+1)'(D);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem[rp_ff];
  assign count     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (ce && push && !flush)
      mem[wp_ff] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wp_ff  <= '0;
        rp_ff  <= '0;
        cnt_ff <= '0;
      end
      else
      begin
        wp_ff  <= wp_ff + AW'(push);
        rp_ff  <= rp_ff + AW'(pop);
        cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule // ulm_fifo

////////////////////////////////////////////////////////////////////////////////

module ulm_uart
  import ulm_pkg::*;
#(
  parameter int QDEPTH = 16
) (
  input  wire logic       MCLK,
  input  wire logic       RESETN,
  input  wire logic       CE,
  input  wire logic [3:0] ADDR,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  input  wire logic [7:0] WDATA,
  output logic [7:0]      RDATA,
  input  wire logic       SERIAL_RX_PIN,
  output logic            SERIAL_TX_PIN,
  input  wire logic       CTS_N,
  input  wire logic       DSR_N,
  input  wire logic       RI_N,
  input  wire logic       DCD_N,
  output logic            RTS_N,
  output logic            DTR_N,
  output logic            IRQ,
  output logic            RXRDY_N,
  output logic            TXRDY_N
);
  localparam int CW = $clog2(QDEPTH) + 1;
  if (QDEPTH < 16) begin : g_bad_q
    $error("ulm_uart queue depth must be at least 16");
  end

  // registers
  logic [7:0]   lctl_ff, scr_ff, rdata_ff;
  logic [4:0]   mctl_ff;
  logic [15:0]  div_ff, dcnt_ff;
  logic [3:0]   ien_ff, msr_ff, dlt_ff;
  logic         fen_ff, dma_ff;
  logic [1:0]   trig_sel_ff;
  logic [4:0]   in_meta_ff, in_sync_ff;
  logic         serial_tx_pin_ff, rts_ff, dtr_ff, irq_ff, rxrdy_ff, txrdy_ff;
  logic         oe_ff, pe_ff, fe_ff, bi_ff, rfe_ff, head_chk_ff;
  logic [CW-1:0] err_cnt_ff;
  ulm_state_t   tx_st_ff, rx_st_ff;
  logic [7:0]   tx_sh_ff, rx_sh_ff;
  logic [4:0]   tx_tk_ff, rx_tk_ff;
  logic [2:0]   tx_bit_ff, rx_bit_ff;
  logic         tx_par_ff, rx_prev_ff, rx_zero_ff, rx_pe_ff;
  logic         rx_push_ff;
  ulm_rx_char_t rx_word_ff;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic rd, wr, dlab, loop, tick, wr_fcr, rd_lsr, rd_msr, wr_thr, rd_rbr;
  logic [1:0] wl;
  assign rd     = CE & RD_STB;
  assign wr     = CE & WR_STB;
  assign dlab   = lctl_ff[LC_DIV];
  assign loop   = mctl_ff[MC_LOOP];
  assign wl     = lctl_ff[1:0]; // R8
  assign wr_thr = wr & (ADDR == ADR_DATA) & ~dlab; // R1
  assign rd_rbr = rd & (ADDR == ADR_DATA) & ~dlab; // R1
  assign wr_fcr = wr & (ADDR == ADR_FCTL);
  assign rd_lsr = rd & (ADDR == ADR_LSTAT);
  assign rd_msr = rd & (ADDR == ADR_MSTAT);
  assign tick   = dcnt_ff == div_ff - 16'h0001; // R24

  // queue resets: pulses only, nothing stored
  logic flush_rx, flush_tx;
  assign flush_rx = wr_fcr & (WDATA[FC_RXR] | (WDATA[FC_EN] != fen_ff)); // R21
  assign flush_tx = wr_fcr & (WDATA[FC_TXR] | (WDATA[FC_EN] != fen_ff)); // R21

  ////////////////////////////////////////////////////////////////////////////
  // queues
  logic         tx_valid, tx_in_ready, tx_pop, rx_valid, rx_in_ready, rx_pop;
  logic [7:0]   tx_head;
  ulm_rx_char_t rx_head;
  logic [CW-1:0] tx_cnt, rx_cnt;

  ulm_fifo #(.W(8), .D(QDEPTH)) u_txq ( // R23
    .clk(MCLK), .rst_n(RESETN), .ce(CE), .flush(flush_tx),
    .in_valid(wr_thr & (fen_ff | ~tx_valid)), .in_ready(tx_in_ready),
    .in_data(WDATA), .out_valid(tx_valid), .out_ready(tx_pop),
    .out_data(tx_head), .count(tx_cnt)
  );

  ulm_fifo #(.W($bits(ulm_rx_char_t)), .D(QDEPTH)) u_rxq ( // R23
    .clk(MCLK), .rst_n(RESETN), .ce(CE), .flush(flush_rx),
    .in_valid(rx_push_ff), .in_ready(rx_in_ready), .in_data(rx_word_ff),
    .out_valid(rx_valid), .out_ready(rx_pop), .out_data(rx_head),
    .count(rx_cnt)
  );

  // without queues the newer character displaces the unread one
  logic rx_drop, ovr_set, rx_trig;
  logic [4:0] trig;
  assign rx_drop = rx_push_ff & ~fen_ff & rx_valid & ~rd_rbr; // R13
  assign rx_pop  = rd_rbr | rx_drop;
  assign ovr_set = rx_push_ff & (fen_ff ? ~rx_in_ready : rx_drop); // R13
  assign trig    = trig_sel_ff == 2'b00 ? TRIG_1 : trig_sel_ff == 2'b01 ? TRIG_4 :
                   trig_sel_ff == 2'b10 ? TRIG_8 : TRIG_14; // R20
  assign rx_trig = fen_ff ? (rx_cnt > CW'(trig)) : rx_valid; // R20

  ////////////////////////////////////////////////////////////////////////////
  // modem inputs
  logic [3:0] mdm;
  logic       sin_s;
  assign sin_s = in_sync_ff[4];
  assign mdm = loop ? {mctl_ff[MC_IRQ], mctl_ff[MC_RI], mctl_ff[MC_DTR],
                       mctl_ff[MC_RTS]} : ~in_sync_ff[3:0]; // R16 R18
  logic [3:0] dlt_set;
  assign dlt_set = {mdm[3] ^ msr_ff[3], msr_ff[2] & ~mdm[2],
                    mdm[1:0] ^ msr_ff[1:0]}; // R19

  ////////////////////////////////////////////////////////////////////////////
  // serial line
  logic tx_line, rx_in, tx_bit_end, tx_stop_end, rx_end;
  logic [4:0] stop_last;
  assign tx_line = tx_st_ff == ST_START ? 1'b0 : tx_st_ff == ST_DATA ? tx_sh_ff[0] :
                   tx_st_ff == ST_PAR ? tx_par_ff : 1'b1; // R3 R6
  assign rx_in   = loop ? tx_line : sin_s; // R15
  assign stop_last = ~lctl_ff[LC_STOP] ? TK_BIT : (wl == 2'b00 ? TK_S15 : TK_S2); // R7
  assign tx_bit_end  = tick & (tx_tk_ff == TK_BIT);
  assign tx_stop_end = tick & (tx_tk_ff == stop_last);
  assign tx_pop      = tx_st_ff == ST_IDLE;
  assign rx_end      = tick & (rx_tk_ff == TK_BIT); // R25

  logic [7:0] rx_data;
  assign rx_data = rx_sh_ff >> (2'd3 - wl); // R8

  logic [7:0] line_condition_status;
  assign line_condition_status = {rfe_ff, ~tx_valid & (tx_st_ff == ST_IDLE), ~tx_valid, // R10 R11
                bi_ff, fe_ff, pe_ff, oe_ff, rx_valid}; // R14

  logic [7:0] rd_mux;
  assign rd_mux = ADDR == ADR_DATA  ? (dlab ? div_ff[7:0] : rx_head.data) : // R1 R2
                  ADDR == ADR_IEN   ? (dlab ? div_ff[15:8] : {4'h0, ien_ff}) :
                  ADDR == ADR_FCTL  ? {fen_ff, fen_ff, 5'h00, ~irq_ff} :
                  ADDR == ADR_LCTL  ? lctl_ff :
                  ADDR == ADR_MCTL  ? {3'h0, mctl_ff} :
                  ADDR == ADR_LSTAT ? line_condition_status :
                  ADDR == ADR_MSTAT ? {msr_ff, dlt_ff} :
                  ADDR == ADR_SCR   ? scr_ff : 8'h00;

  logic [3:0] flag_set;
  assign flag_set = head_chk_ff & rx_valid ?
                    {rx_head.brk, rx_head.fe, rx_head.pe, 1'b0} : 4'h0; // R12

  logic irq_src;
  assign irq_src = (ien_ff[0] & rx_trig) | (ien_ff[1] & ~tx_valid) |
                   (ien_ff[2] & (oe_ff | pe_ff | fe_ff | bi_ff)) | (ien_ff[3] & |dlt_ff);

  ////////////////////////////////////////////////////////////////////////////
  // host registers and status
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      lctl_ff <= LCTL_RST; mctl_ff <= MCTL_RST; div_ff <= DIV_RST;
      scr_ff <= 8'h00; ien_ff <= 4'h0; fen_ff <= 1'b0; dma_ff <= 1'b0;
      trig_sel_ff <= 2'b00; rdata_ff <= 8'h00; dcnt_ff <= 16'h0000;
      in_meta_ff <= 5'h1F; in_sync_ff <= 5'h1F; msr_ff <= 4'h0; dlt_ff <= 4'h0;
      {oe_ff, pe_ff, fe_ff, bi_ff, rfe_ff, head_chk_ff} <= 6'h00;
      err_cnt_ff <= '0;
      {serial_tx_pin_ff, rts_ff, dtr_ff, irq_ff, rxrdy_ff, txrdy_ff} <= 6'h3A;
    end
    else if (CE)
    begin
      in_meta_ff <= {SERIAL_RX_PIN, DCD_N, RI_N, DSR_N, CTS_N};
      in_sync_ff <= in_meta_ff;
      dcnt_ff    <= (tick | (wr & dlab & (ADDR == ADR_DATA || ADDR == ADR_IEN))) ?
                    16'h0000 : dcnt_ff + 16'h0001; // R24
      if (wr && ADDR == ADR_DATA && dlab) div_ff[7:0] <= WDATA; // R1 R2
      if (wr && ADDR == ADR_IEN && dlab) div_ff[15:8] <= WDATA; // R1 R2
      if (wr && ADDR == ADR_IEN && !dlab) ien_ff <= WDATA[3:0];
      if (wr && ADDR == ADR_LCTL) lctl_ff <= WDATA;
      if (wr && ADDR == ADR_MCTL) mctl_ff <= WDATA[4:0];
      if (wr && ADDR == ADR_SCR) scr_ff <= WDATA;
      if (wr_fcr)
      begin
        fen_ff      <= WDATA[FC_EN]; // R22
        dma_ff      <= WDATA[FC_DMA];
        trig_sel_ff <= WDATA[7:6]; // R20
      end
      if (rd) rdata_ff <= rd_mux;
      msr_ff <= mdm; // R18
      dlt_ff <= (dlt_ff & ~{4{rd_msr}}) | dlt_set; // R19
      oe_ff  <= (oe_ff & ~rd_lsr) | ovr_set; // R13
      {bi_ff, fe_ff, pe_ff} <= ({bi_ff, fe_ff, pe_ff} & ~{3{rd_lsr}}) | flag_set[3:1]; // R12
      head_chk_ff <= ~flush_rx & (rx_pop | (rx_push_ff & ~rx_valid));
      err_cnt_ff <= flush_rx ? '0 : err_cnt_ff
                    + CW'(rx_push_ff & rx_in_ready & (rx_word_ff.brk | rx_word_ff.fe |
                                                       rx_word_ff.pe))
                    - CW'(rx_pop & rx_valid & (rx_head.brk | rx_head.fe | rx_head.pe));
      rfe_ff <= fen_ff & ((err_cnt_ff != '0) | (rfe_ff & ~rd_lsr)); // R9
      serial_tx_pin_ff  <= loop | (~lctl_ff[LC_BRK] & tx_line); // R4 R15
      rts_ff   <= loop | ~mctl_ff[MC_RTS]; // R15 R17
      dtr_ff   <= loop | ~mctl_ff[MC_DTR]; // R15 R17
      irq_ff   <= mctl_ff[MC_IRQ] & irq_src; // R17
      rxrdy_ff <= (fen_ff & dma_ff) ? ~rx_trig : ~rx_valid; // R22
      txrdy_ff <= (fen_ff & dma_ff) ? ~tx_in_ready : tx_valid; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_st_ff <= ST_IDLE; tx_sh_ff <= 8'h00; tx_tk_ff <= 5'h00;
      tx_bit_ff <= 3'h0; tx_par_ff <= 1'b0;
    end
    else if (CE)
    begin
      if (tx_st_ff != ST_IDLE && tick) tx_tk_ff <= tx_tk_ff + 5'h01;
      unique case (tx_st_ff)
        ST_IDLE:
          if (tx_valid)
          begin
            tx_st_ff  <= ST_START;
            tx_sh_ff  <= tx_head;
            tx_tk_ff  <= 5'h00;
            tx_bit_ff <= 3'h0;
            tx_par_ff <= ulm_parity(tx_head, wl, lctl_ff[LC_EVEN], lctl_ff[LC_STICK]); // R5
          end
        ST_START:
          if (tx_bit_end) begin tx_st_ff <= ST_DATA; tx_tk_ff <= 5'h00; end
        ST_DATA:
          if (tx_bit_end)
          begin
            tx_tk_ff  <= 5'h00;
            tx_sh_ff  <= tx_sh_ff >> 1; // R3
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == {1'b1, wl}) tx_st_ff <= lctl_ff[LC_PAR] ? ST_PAR : ST_STOP; // R6 R8
          end
        ST_PAR:
          if (tx_bit_end) begin tx_st_ff <= ST_STOP; tx_tk_ff <= 5'h00; end
        ST_STOP:
          if (tx_stop_end) tx_st_ff <= ST_IDLE; // R7
        default: tx_st_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_st_ff <= ST_IDLE; rx_sh_ff <= 8'h00; rx_tk_ff <= 5'h00; rx_bit_ff <= 3'h0;
      {rx_prev_ff, rx_zero_ff, rx_pe_ff, rx_push_ff} <= 4'h8; rx_word_ff <= '0;
    end
    else if (CE)
    begin
      rx_prev_ff <= rx_in;
      rx_push_ff <= 1'b0;
      if (rx_st_ff != ST_IDLE && tick) rx_tk_ff <= rx_tk_ff + 5'h01;
      unique case (rx_st_ff)
        ST_IDLE:
          if (rx_prev_ff && !rx_in) begin rx_st_ff <= ST_START; rx_tk_ff <= 5'h00; end
        ST_START:
          if (tick && rx_tk_ff == TK_HALF) // R25
          begin
            rx_st_ff   <= rx_in ? ST_IDLE : ST_DATA;
            rx_tk_ff   <= 5'h00;
            rx_bit_ff  <= 3'h0;
            rx_zero_ff <= 1'b1;
            rx_pe_ff   <= 1'b0;
          end
        ST_DATA:
          if (rx_end)
          begin
            rx_tk_ff   <= 5'h00;
            rx_sh_ff   <= {rx_in, rx_sh_ff[7:1]}; // R3
            rx_zero_ff <= rx_zero_ff & ~rx_in;
            rx_bit_ff  <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == {1'b1, wl}) rx_st_ff <= lctl_ff[LC_PAR] ? ST_PAR : ST_STOP; // R6 R8
          end
        ST_PAR:
          if (rx_end)
          begin
            rx_st_ff   <= ST_STOP;
            rx_tk_ff   <= 5'h00;
            rx_zero_ff <= rx_zero_ff & ~rx_in;
            rx_pe_ff   <= rx_in != ulm_parity(rx_data, wl, lctl_ff[LC_EVEN],
                                              lctl_ff[LC_STICK]); // R5 R6
          end
        ST_STOP:
          if (rx_end)
          begin
            rx_st_ff   <= ST_IDLE;
            rx_push_ff <= 1'b1;
            rx_word_ff <= '{brk: rx_zero_ff & ~rx_in, fe: ~rx_in, pe: rx_pe_ff,
                            data: rx_data}; // R12
          end
        default: rx_st_ff <= ST_IDLE;
      endcase
    end
  end

  assign RDATA   = rdata_ff;
  assign SERIAL_TX_PIN    = serial_tx_pin_ff;
  assign RTS_N   = rts_ff;
  assign DTR_N   = dtr_ff;
  assign IRQ     = irq_ff;
  assign RXRDY_N = rxrdy_ff;
  assign TXRDY_N = txrdy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  sequence s_stop15;
    CE && tx_st_ff == ST_STOP && lctl_ff[LC_STOP] && wl == 2'b00;
  endsequence
  sequence s_last_tick;
    tick && tx_tk_ff == TK_S15;
  endsequence

  break_pin_a: assert property (CE && lctl_ff[LC_BRK] && !loop |=> !SERIAL_TX_PIN) // R4
    else $error("break did not hold output low");
  loop_pins_a: assert property (CE && loop |=> SERIAL_TX_PIN && RTS_N && DTR_N) // R15
    else $error("loopback left pins active");
  rts_drive_a: assert property (CE && !loop |=> RTS_N != $past(mctl_ff[MC_RTS])) // R17
    else $error("request-to-send pin not inverse of control");
  rx_ready_a: assert property (rd_lsr |=> RDATA[0] == $past(rx_valid)) // R14
    else $error("receive ready bit wrong");
  tx_idle_a: assert property (rd_lsr |=> // R10
      RDATA[6] == $past(!tx_valid && tx_st_ff == ST_IDLE))
    else $error("transmitter idle bit wrong");
  ovr_clear_a: assert property (rd_lsr && !ovr_set |=> !oe_ff) // R13
    else $error("overrun not cleared by status read");
  stop_half_a: assert property (s_stop15 and s_last_tick |=> tx_st_ff == ST_IDLE) // R7
    else $error("one and a half stop bits not ended on time");
  qerr_off_a: assert property (CE && !fen_ff && !wr_fcr |=> !rfe_ff) // R9
    else $error("queue error set outside queue mode");
  msr_loop_a: assert property (CE && loop ##1 CE && $stable(mctl_ff) |=> // R16
      msr_ff == {$past(mctl_ff[3]), $past(mctl_ff[2]), $past(mctl_ff[0]),
                 $past(mctl_ff[1])})
    else $error("loopback modem status mismatch");
endmodule // ulm_uart

`default_nettype wire

//--- verification/ulm_remote.sv
`timescale 1ns/1ps
`default_nettype none
module ulm_remote (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [11:0] frame;
  int          nfr = 0;
  initial line_out = 1'b1;
  // twelve slots after a start edge, mid-bit, 16 clocks a bit
  always
  begin
    @(negedge line_in);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      repeat (16) @(posedge clk);
      frame[i] = line_in;
    end
    nfr++;
  end
  // start bit, then slots lsb first; idle high afterwards
  task automatic send(input logic [11:0] f);
    @(negedge clk) line_out = 1'b0;
    repeat (16) @(negedge clk);
    for (int i = 0; i < 12; i++)
    begin
      line_out = f[i];
      repeat (16) @(negedge clk);
    end
    line_out = 1'b1;
  endtask
endmodule // ulm_remote
`default_nettype wire

//--- verification/ulm_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ulm_uart_tb;
  import ulm_pkg::*;
  logic       MCLK, RESETN, CE, WR_STB, RD_STB, SERIAL_RX_PIN, CTS_N, RI_N, DSR_N, DCD_N;
  logic       SERIAL_TX_PIN, RTS_N, DTR_N, IRQ, RXRDY_N, TXRDY_N;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA, r, lc, d;
  int         fails = 0, n_tests = 0, k;

  ulm_uart ulm_uart_i (.MCLK(MCLK), .RESETN(RESETN), .CE(CE), .ADDR(ADDR),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .WDATA(WDATA), .RDATA(RDATA), .SERIAL_RX_PIN(SERIAL_RX_PIN),
    .SERIAL_TX_PIN(SERIAL_TX_PIN), .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N), .DCD_N(DCD_N),
    .RTS_N(RTS_N), .DTR_N(DTR_N), .IRQ(IRQ), .RXRDY_N(RXRDY_N), .TXRDY_N(TXRDY_N));
  ulm_remote ulm_remote_i (.clk(MCLK), .line_in(SERIAL_TX_PIN), .line_out(SERIAL_RX_PIN));

  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge MCLK);
    ADDR = a;
    WDATA = v;
    WR_STB = 1'b1;
    @(negedge MCLK);
    WR_STB = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge MCLK);
    ADDR = a;
    RD_STB = 1'b1;
    @(negedge MCLK);
    RD_STB = 1'b0;
    v = RDATA;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  task automatic waitfr(input int old);
    int j;
    for (j = 0; j < 600 && ulm_remote_i.nfr == old; j++)
      @(negedge MCLK);
    if (j == 600)
    begin
      fails++;
      finish_test();
    end
  endtask

  // expected slots after the start bit for data dd under line control c
  function automatic logic [11:0] frm(input logic [7:0] dd, input logic [7:0] c);
    int         nb;
    logic       p;
    logic [11:0] f;
    nb = 5 + c[1:0];
    p = c[5] ? ~c[4] : ((^(dd & ~(8'hFF << nb))) ^ ~c[4]);
    f = 12'hFFF;
    for (int i = 0; i < nb; i++)
      f[i] = dd[i];
    if (c[3])
      f[nb] = p;
    return f;
  endfunction

  initial
  begin
    RESETN = 1'b0;
    {WR_STB, RD_STB, ADDR, WDATA} = '0;
    {CE, CTS_N, RI_N, DSR_N, DCD_N} = 5'h1F;
    void'($urandom(86));
    repeat (3) @(posedge MCLK);
    @(negedge MCLK) RESETN = 1'b1;
    chk({SERIAL_TX_PIN, RTS_N, DTR_N, IRQ, RXRDY_N, TXRDY_N}, 16'h003A);
    rdc(ADR_LCTL, 8'h00);
    rdc(ADR_MCTL, 8'h00);
    rdc(ADR_LSTAT, 8'h60);
    d = 8'($urandom);
    wr(ADR_SCR, d);
    rdc(ADR_SCR, d);
    CE = 1'b0;
    wr(ADR_SCR, ~d);
    CE = 1'b1;
    rdc(ADR_SCR, d);
    wr(ADR_LCTL, 8'h80);
    rdc(ADR_DATA, 8'h01);
    wr(ADR_DATA, 8'h5A);
    wr(ADR_IEN, 8'hC3);
    rdc(ADR_DATA, 8'h5A);
    rdc(ADR_IEN, 8'hC3);
    wr(ADR_DATA, 8'h01);
    wr(ADR_IEN, 8'h00);
    wr(ADR_LCTL, 8'h00);
    wr(ADR_IEN, 8'hFF);
    rdc(ADR_IEN, 8'h0F);
    wr(ADR_IEN, 8'h00);
    $display("done registers");
    for (int i = 0; i < 12; i++)
    begin
      lc = {2'b00, 4'($urandom), 2'(i)};
      if (i == 0)
        lc[LC_STOP] = 1'b1;
      d = 8'($urandom);
      wr(ADR_LCTL, lc);
      k = ulm_remote_i.nfr;
      wr(ADR_DATA, d);
      cyc(40);
      rdc(ADR_LSTAT, 8'h20);
      waitfr(k);
      chk(ulm_remote_i.frame, frm(d, lc));
      cyc(40);
      rdc(ADR_LSTAT, 8'h60);
    end
    $display("done transmit");
    wr(ADR_MCTL, 8'h13);
    wr(ADR_LCTL, 8'h03);
    d = 8'($urandom);
    wr(ADR_DATA, d);
    cyc(40);
    chk({SERIAL_TX_PIN, RTS_N, DTR_N}, 16'h0007);
    cyc(250);
    rdc(ADR_DATA, d);
    wr(ADR_MCTL, 8'h1F);
    cyc(4);
    rd(ADR_MSTAT, r);
    chk(r & 8'hF0, 8'hF0);
    wr(ADR_MCTL, 8'h15);
    cyc(4);
    rd(ADR_MSTAT, r);
    chk(r & 8'hF0, 8'h60);
    wr(ADR_MCTL, 8'h03);
    cyc(4);
    chk({RTS_N, DTR_N}, 16'h0000);
    wr(ADR_MCTL, 8'h00);
    cyc(4);
    rd(ADR_MSTAT, r);
    CTS_N = 1'b0;
    cyc(5);
    rdc(ADR_MSTAT, 8'h11);
    RI_N = 1'b0;
    cyc(5);
    rdc(ADR_MSTAT, 8'h50);
    RI_N = 1'b1;
    cyc(5);
    rdc(ADR_MSTAT, 8'h14);
    {DSR_N, DCD_N} = 2'b00;
    cyc(5);
    rdc(ADR_MSTAT, 8'hBA);
    {CTS_N, DSR_N, DCD_N} = 3'b111;
    cyc(5);
    rdc(ADR_MSTAT, 8'h0B);
    $display("done modem");
    wr(ADR_LCTL, 8'h1B);
    wr(ADR_IEN, 8'h01);
    ulm_remote_i.send(frm(d, 8'h1B));
    ulm_remote_i.send(frm(~d, 8'h1B));
    cyc(4);
    chk(IRQ, 16'h0000);
    chk(RXRDY_N, 16'h0000);
    wr(ADR_MCTL, 8'h08);
    cyc(2);
    chk(IRQ, 16'h0001);
    rdc(ADR_LSTAT, 8'h63);
    rdc(ADR_DATA, ~d);
    rdc(ADR_LSTAT, 8'h60);
    wr(ADR_IEN, 8'h00);
    ulm_remote_i.send(frm(d, 8'h1B) ^ 12'h100);
    cyc(4);
    rdc(ADR_LSTAT, 8'h65);
    rdc(ADR_DATA, d);
    rdc(ADR_LSTAT, 8'h60);
    ulm_remote_i.send(12'h000);
    cyc(4);
    rdc(ADR_LSTAT, 8'h79);
    rdc(ADR_DATA, 8'h00);
    $display("done receive");
    wr(ADR_FCTL, 8'h01);
    rdc(ADR_FCTL, 8'hC1);
    wr(ADR_FCTL, 8'h09);
    ulm_remote_i.send(frm(d, 8'h1B) ^ 12'h100);
    ulm_remote_i.send(frm(~d, 8'h1B));
    cyc(4);
    chk(RXRDY_N, 16'h0000);
    rdc(ADR_LSTAT, 8'hE5);
    rdc(ADR_DATA, d);
    cyc(4);
    chk(RXRDY_N, 16'h0001);
    rdc(ADR_LSTAT, 8'hE1);
    rdc(ADR_LSTAT, 8'h61);
    wr(ADR_FCTL, 8'h03);
    rdc(ADR_LSTAT, 8'h60);
    rdc(ADR_FCTL, 8'hC1);
    wr(ADR_FCTL, 8'h09);
    repeat (18) wr(ADR_DATA, 8'($urandom));
    chk(TXRDY_N, 16'h0001);
    wr(ADR_FCTL, 8'h0D);
    cyc(2);
    chk(TXRDY_N, 16'h0000);
    cyc(250);
    $display("done queues");
    wr(ADR_FCTL, 8'h00);
    wr(ADR_LCTL, 8'h43);
    cyc(2);
    chk(SERIAL_TX_PIN, 16'h0000);
    wr(ADR_LCTL, 8'h03);
    cyc(250);
    $display("done break");
    finish_test();
  end
endmodule // ulm_uart_tb
`default_nettype wire
